// ==== verilog/kmwi_pkg.sv ====
// Constants shared by the keyboard and mouse wake and isolation glue.
// Assumes one 40 MHz clock and an AXI4-Lite register master.
// Operation
// - Latch selects and isolation bits at 0xF0
// - Mouse irq: AND with latch, or latch
// - Keyboard irq: AND with latch, or latch
// - Four distinct wake status bits raised
// - Wake needs event enable and global enable
// - Irq wakes need main power; edges don't
// - Mouse isolate blocks core; wake still sees
// - Keyboard isolate blocks core; wake still sees
// - Core reset bit holds until cleared
package kmwi_pkg;
  // Register byte addresses
  localparam logic [11:0] ADDR_CORE_RST  = 12'h02C;
  localparam logic [11:0] ADDR_ISO_CTRL  = 12'h0F0;
  localparam logic [11:0] ADDR_WAKE_STS  = 12'h100;
  localparam logic [11:0] ADDR_WAKE_EN   = 12'h104;
  localparam logic [11:0] ADDR_IRQ_MASK  = 12'h108;
  // Field positions
  localparam int CORE_RST_BIT    = 6;
  localparam int MOUSE_ISO_BIT   = 6;
  localparam int KBD_ISO_BIT     = 5;
  localparam int MOUSE_LATCH_BIT = 4;
  localparam int KBD_LATCH_BIT   = 3;
  localparam int EV_KBD_IRQ      = 0;
  localparam int EV_MOUSE_IRQ    = 1;
  localparam int EV_KBD_DATA     = 2;
  localparam int EV_MOUSE_DATA   = 3;
  localparam int GLOBAL_WAKE_BIT = 4;
  localparam int NUM_EV          = 4;
  // Reset values
  localparam logic [7:0] CORE_RST_RESET  = 8'h00;
  localparam logic [7:0] ISO_CTRL_RESET  = 8'h00;
  localparam logic [4:0] WAKE_EN_RESET   = 5'h00;
  localparam logic [3:0] IRQ_MASK_RESET  = 4'h0;
  localparam logic [3:0] WAKE_STS_RESET  = 4'h0;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== verilog/kmwi_irq_latch.sv ====
// Latched copy of one core interrupt and its selectable output.
// Assumes core_irq and rearm are synchronous to aclk.
`timescale 1ns/1ps
module kmwi_irq_latch (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Core side
  input  wire logic core_irq,
  input  wire logic rearm,
  // Control
  input  wire logic latch_sel,
  // Results
  output logic      irq_out,
  output logic      rise
);
  logic prev_r, prev_nxt;
  logic latch_r, latch_nxt;
  logic out_r, out_nxt;

  // Rising edge catches short pulses; set wins over rearm
  always_comb begin
    rise      = core_irq & ~prev_r;
    prev_nxt  = core_irq;
    latch_nxt = latch_r;
    if (rise) begin
      latch_nxt = 1'b1;
    end else if (rearm && !core_irq) begin
      latch_nxt = 1'b0;
    end
    // Select raw AND latched, or latched alone
    out_nxt = latch_sel ? latch_nxt : (core_irq & latch_nxt);
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r  <= 1'b0;
      latch_r <= 1'b0;
      out_r   <= 1'b0;
    end else begin
      prev_r  <= prev_nxt;
      latch_r <= latch_nxt;
      out_r   <= out_nxt;
    end
  end

  assign irq_out = out_r;
endmodule

// ==== verilog/kmwi_fall_det.sv ====
// Falling edge detector for one keyboard or mouse data line.
// Assumes the line is already synchronous and idles high.
`timescale 1ns/1ps
module kmwi_fall_det (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Line and pulse
  input  wire logic line,
  output logic      fall
);
  logic prev_r, prev_nxt;

  // Prior level resets high, so a line held low at reset gives a fall on the first cycle after reset
  always_comb begin
    prev_nxt = line;
    fall     = prev_r & ~line;
  end

  // Prior level register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= prev_nxt;
    end
  end
endmodule

// ==== verilog/kmwi_top.sv ====
// Keyboard and mouse interrupt latching, wake status, line isolation
// and core reset hold, with an AXI4-Lite register slave.
// Assumes all line inputs are synchronous to aclk.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
module kmwi_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Power state
  input  wire logic        main_power_ok,
  // External keyboard and mouse lines
  input  wire logic        kbd_clock_line,
  input  wire logic        kbd_data_line,
  input  wire logic        mouse_clock_line,
  input  wire logic        mouse_data_line,
  // Lines into the controller core
  output logic             core_kbd_clock,
  output logic             core_kbd_data,
  output logic             core_mouse_clock,
  output logic             core_mouse_data,
  // Core interrupts and rearm strobes
  input  wire logic        core_kbd_irq,
  input  wire logic        core_mouse_irq,
  input  wire logic        core_kbd_irq_ack,
  input  wire logic        core_mouse_irq_ack,
  // Interrupt, wake and reset outputs
  output logic             kbd_irq_line,
  output logic             mouse_irq_line,
  output logic             core_reset,
  output logic             pme_out,
  output logic             irq
);
  // Register state
  logic [7:0] core_rst_r, core_rst_nxt;
  logic [7:0] iso_r, iso_nxt;
  logic [4:0] wake_en_r, wake_en_nxt;
  logic [3:0] mask_r, mask_nxt;
  logic [3:0] sts_r, sts_nxt;
  // Write channel state
  logic        aw_full_r, aw_full_nxt;
  logic [11:0] aw_addr_r, aw_addr_nxt;
  logic        w_full_r, w_full_nxt;
  logic [7:0]  w_data_r, w_data_nxt;
  logic        w_lane_r, w_lane_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  // Read channel state
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  // Line and output state
  logic [3:0]  core_lines_r, core_lines_nxt;
  logic        pme_r, pme_nxt;
  logic        irq_r, irq_nxt;
  // Events and strobes
  logic [3:0]  events;
  logic        kbd_rise, mouse_rise;
  logic        kbd_fall, mouse_fall;
  logic        do_write, rd_take;

  // Interrupt latches for both channels
  kmwi_irq_latch u_kbd_latch (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .core_irq  (core_kbd_irq),
    .rearm     (core_kbd_irq_ack),
    .latch_sel (iso_r[kmwi_pkg::KBD_LATCH_BIT]),
    .irq_out   (kbd_irq_line),
    .rise      (kbd_rise)
  );

  kmwi_irq_latch u_mouse_latch (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .core_irq  (core_mouse_irq),
    .rearm     (core_mouse_irq_ack),
    .latch_sel (iso_r[kmwi_pkg::MOUSE_LATCH_BIT]),
    .irq_out   (mouse_irq_line),
    .rise      (mouse_rise)
  );

  // Data line edge detectors see the raw lines, never the isolated ones
  kmwi_fall_det u_kbd_fall (
    .aclk    (aclk),
    .aresetn (aresetn),
    .line    (kbd_data_line),
    .fall    (kbd_fall)
  );

  kmwi_fall_det u_mouse_fall (
    .aclk    (aclk),
    .aresetn (aresetn),
    .line    (mouse_data_line),
    .fall    (mouse_fall)
  );

  // Wake events; interrupt events only count on main power
  // Data line events stay live on the standby rail, so a keyboard or
  // mouse can still wake the system while the core is unpowered
  always_comb begin
    events = 4'h0;
    events[kmwi_pkg::EV_KBD_IRQ]    = kbd_rise & main_power_ok;
    events[kmwi_pkg::EV_MOUSE_IRQ]  = mouse_rise & main_power_ok;
    events[kmwi_pkg::EV_KBD_DATA]   = kbd_fall;
    events[kmwi_pkg::EV_MOUSE_DATA] = mouse_fall;
  end

  // Handshake outputs; one write and one read in flight at most
  // Ready stays low while a half is held or a response waits: this trades
  // throughput for a single one-word write buffer
  assign s_axi_awready = ~aw_full_r & ~bvalid_r;
  assign s_axi_wready  = ~w_full_r & ~bvalid_r;
  assign s_axi_arready = ~rvalid_r;
  assign do_write      = aw_full_r & w_full_r;
  assign rd_take       = s_axi_arvalid & ~rvalid_r;

  // Write channel: address and data held separately, taken in any order
  always_comb begin
    aw_full_nxt = aw_full_r;
    aw_addr_nxt = aw_addr_r;
    w_full_nxt  = w_full_r;
    w_data_nxt  = w_data_r;
    w_lane_nxt  = w_lane_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_nxt = 1'b1;
      w_data_nxt = s_axi_wdata[7:0];
      w_lane_nxt = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      case ({aw_addr_r[11:2], 2'b00})
        kmwi_pkg::ADDR_CORE_RST,
        kmwi_pkg::ADDR_ISO_CTRL,
        kmwi_pkg::ADDR_WAKE_STS,
        kmwi_pkg::ADDR_WAKE_EN,
        kmwi_pkg::ADDR_IRQ_MASK: bresp_nxt = kmwi_pkg::RESP_OKAY;
        default:                 bresp_nxt = kmwi_pkg::RESP_SLVERR;
      endcase
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  // Registers written by software; only byte lane 0 carries data
  // Hardware does not police which core reset bits software sets; every
  // bit is stored and only bit 6 reaches the core
  always_comb begin
    core_rst_nxt = core_rst_r;
    iso_nxt      = iso_r;
    wake_en_nxt  = wake_en_r;
    mask_nxt     = mask_r;
    if (do_write && w_lane_r) begin
      case ({aw_addr_r[11:2], 2'b00})
        kmwi_pkg::ADDR_CORE_RST: core_rst_nxt = w_data_r;
        kmwi_pkg::ADDR_ISO_CTRL: iso_nxt      = w_data_r;
        kmwi_pkg::ADDR_WAKE_EN:  wake_en_nxt  = w_data_r[4:0];
        kmwi_pkg::ADDR_IRQ_MASK: mask_nxt     = w_data_r[3:0];
        default:                 core_rst_nxt = core_rst_r;
      endcase
    end
  end

  // Read channel; a status read clears what it returns
  // Read data come from flip-flops and hold until rready is seen
  // Unmapped reads answer with an error and zero data
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rd_take) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = kmwi_pkg::RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      case ({s_axi_araddr[11:2], 2'b00})
        kmwi_pkg::ADDR_CORE_RST: rdata_nxt[7:0] = core_rst_r;
        kmwi_pkg::ADDR_ISO_CTRL: rdata_nxt[7:0] = iso_r;
        kmwi_pkg::ADDR_WAKE_STS: rdata_nxt[3:0] = sts_r;
        kmwi_pkg::ADDR_WAKE_EN:  rdata_nxt[4:0] = wake_en_r;
        kmwi_pkg::ADDR_IRQ_MASK: rdata_nxt[3:0] = mask_r;
        default:                 rresp_nxt      = kmwi_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // Sticky wake status; a new event in the clearing cycle survives
  // A clearing read returns the value from before the clear
  always_comb begin
    sts_nxt = sts_r;
    if (rd_take && ({s_axi_araddr[11:2], 2'b00} == kmwi_pkg::ADDR_WAKE_STS)) begin
      sts_nxt = 4'h0;
    end
    sts_nxt = sts_nxt | events;
  end

  // Isolation, wake and interrupt outputs
  always_comb begin
    // Isolated lines read as idle high so the core sees no traffic
    core_lines_nxt[0] = kbd_clock_line | iso_r[kmwi_pkg::KBD_ISO_BIT];
    core_lines_nxt[1] = kbd_data_line | iso_r[kmwi_pkg::KBD_ISO_BIT];
    core_lines_nxt[2] = mouse_clock_line | iso_r[kmwi_pkg::MOUSE_ISO_BIT];
    core_lines_nxt[3] = mouse_data_line | iso_r[kmwi_pkg::MOUSE_ISO_BIT];
    // Wake and interrupt use the next status so they move with the status bit
    pme_nxt = wake_en_r[kmwi_pkg::GLOBAL_WAKE_BIT] & (|(sts_nxt & wake_en_r[3:0]));
    irq_nxt = |(sts_nxt & mask_r);
  end

  // All state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Software registers
      core_rst_r   <= kmwi_pkg::CORE_RST_RESET;
      iso_r        <= kmwi_pkg::ISO_CTRL_RESET;
      wake_en_r    <= kmwi_pkg::WAKE_EN_RESET;
      mask_r       <= kmwi_pkg::IRQ_MASK_RESET;
      sts_r        <= kmwi_pkg::WAKE_STS_RESET;
      // Bus channels
      aw_full_r    <= 1'b0;
      aw_addr_r    <= 12'h000;
      w_full_r     <= 1'b0;
      w_data_r     <= 8'h00;
      w_lane_r     <= 1'b0;
      bvalid_r     <= 1'b0;
      bresp_r      <= 2'h0;
      rvalid_r     <= 1'b0;
      rdata_r      <= 32'h0000_0000;
      rresp_r      <= 2'h0;
      // Lines idle high, outputs quiet
      core_lines_r <= 4'hF;
      pme_r        <= 1'b0;
      irq_r        <= 1'b0;
    end else begin
      // Software registers
      core_rst_r   <= core_rst_nxt;
      iso_r        <= iso_nxt;
      wake_en_r    <= wake_en_nxt;
      mask_r       <= mask_nxt;
      sts_r        <= sts_nxt;
      // Bus channels
      aw_full_r    <= aw_full_nxt;
      aw_addr_r    <= aw_addr_nxt;
      w_full_r     <= w_full_nxt;
      w_data_r     <= w_data_nxt;
      w_lane_r     <= w_lane_nxt;
      bvalid_r     <= bvalid_nxt;
      bresp_r      <= bresp_nxt;
      rvalid_r     <= rvalid_nxt;
      rdata_r      <= rdata_nxt;
      rresp_r      <= rresp_nxt;
      // Lines and outputs
      core_lines_r <= core_lines_nxt;
      pme_r        <= pme_nxt;
      irq_r        <= irq_nxt;
    end
  end

  // Output wiring; core reset follows the stored bit, never self-clears
  assign core_reset       = core_rst_r[kmwi_pkg::CORE_RST_BIT];

  // Lines into the core, one cycle behind the pins
  assign core_kbd_clock   = core_lines_r[0];
  assign core_kbd_data    = core_lines_r[1];
  assign core_mouse_clock = core_lines_r[2];
  assign core_mouse_data  = core_lines_r[3];

  // Wake and interrupt levels
  assign pme_out          = pme_r;
  assign irq              = irq_r;

  // Bus responses
  assign s_axi_bvalid     = bvalid_r;
  assign s_axi_bresp      = bresp_r;
  assign s_axi_rvalid     = rvalid_r;
  assign s_axi_rdata      = rdata_r;
  assign s_axi_rresp      = rresp_r;
endmodule

// ==== tb/kmwi_props.sv ====
// Checker for the wake, latch and isolation glue, bound to kmwi_top.
// Assumes the top module's port names and one clock domain.
`timescale 1ns/1ps
module kmwi_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus responses
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  // Power and lines
  input wire logic main_power_ok,
  input wire logic kbd_data_line,
  input wire logic mouse_data_line,
  input wire logic core_kbd_data,
  input wire logic core_mouse_data,
  // Interrupts and outputs
  input wire logic core_kbd_irq,
  input wire logic core_mouse_irq,
  input wire logic kbd_irq_line,
  input wire logic mouse_irq_line,
  input wire logic core_reset,
  input wire logic pme_out,
  input wire logic irq
);
  logic cause_r;
  // A wake event at the last edge; irq events only count with main power up
  always_ff @(posedge aclk) begin
    cause_r <= $fell(kbd_data_line) || $fell(mouse_data_line) ||
      (main_power_ok && ($rose(core_kbd_irq) || $rose(core_mouse_irq)));
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_kbd_irq_rise: assert property ($rose(core_kbd_irq) |=> kbd_irq_line)
    else $error("keyboard irq line missed a rise");
  a_mouse_irq_rise: assert property ($rose(core_mouse_irq) |=> mouse_irq_line)
    else $error("mouse irq line missed a rise");
  a_wake_cause: assert property ($rose(pme_out) |-> cause_r || s_axi_bvalid || $past(s_axi_bvalid))
    else $error("wake output rose without an event");
  a_irq_cause: assert property ($rose(irq) |-> cause_r || s_axi_bvalid || $past(s_axi_bvalid))
    else $error("interrupt rose without an event");
  a_wake_sticky: assert property ($fell(pme_out) |-> s_axi_rvalid || $past(s_axi_rvalid) ||
    $past(s_axi_rvalid, 2) || s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("wake output dropped without a read or write");
  a_core_rst_hold: assert property ($changed(core_reset) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("core reset changed without a write");
  a_kbd_iso_pass: assert property (!core_kbd_data |-> !$past(kbd_data_line))
    else $error("core keyboard data low without the line");
  a_mouse_iso_pass: assert property (!core_mouse_data |-> !$past(mouse_data_line))
    else $error("core mouse data low without the line");
endmodule
bind kmwi_top kmwi_props u_props (.aclk, .aresetn, .s_axi_bvalid, .s_axi_rvalid, .main_power_ok,
  .kbd_data_line, .mouse_data_line, .core_kbd_data, .core_mouse_data, .core_kbd_irq,
  .core_mouse_irq, .kbd_irq_line, .mouse_irq_line, .core_reset, .pme_out, .irq);

// ==== tb/kmwi_far_model.sv ====
// Far side model: external keyboard and mouse lines and the core's irqs.
// Assumes only the bench calls drive(); each value lasts one clock or more.
`timescale 1ns/1ps
module kmwi_far_model (
  // Clock
  input wire logic aclk,
  // External lines, pulled up so they idle high
  output logic     kbd_clock_line,
  output logic     kbd_data_line,
  output logic     mouse_clock_line,
  output logic     mouse_data_line,
  // Core interrupts and rearm strobes
  output logic     core_kbd_irq,
  output logic     core_mouse_irq,
  output logic     core_kbd_irq_ack,
  output logic     core_mouse_irq_ack
);
  logic [7:0] st_r = 8'h0F;
  // Bits 3:0 are lines, 7:4 irqs then acks; acks are pulses of one drive
  assign {core_mouse_irq_ack, core_kbd_irq_ack, core_mouse_irq, core_kbd_irq} = st_r[7:4];
  assign {mouse_data_line, mouse_clock_line, kbd_data_line, kbd_clock_line} = st_r[3:0];
  // Changes land just after a rising edge, never on the sampling edge
  task automatic drive(input logic [7:0] v);
    @(posedge aclk);
    st_r <= v;
  endtask
endmodule

// ==== tb/tb_kmwi_top.sv ====
// Self-checking bench for kmwi_top over AXI4-Lite and the far side model.
// Assumes kmwi_pkg, the checker and the far side model are compiled first.
`timescale 1ns/1ps
module tb_kmwi_top;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, main_power_ok = 1'h1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, bsp;
  logic [31:0] s_axi_rdata, rd;
  logic        kbd_clock_line, kbd_data_line, mouse_clock_line, mouse_data_line;
  logic        core_kbd_irq, core_mouse_irq, core_kbd_irq_ack, core_mouse_irq_ack;
  logic        core_kbd_clock, core_kbd_data, core_mouse_clock, core_mouse_data;
  logic        kbd_irq_line, mouse_irq_line, core_reset, pme_out, irq;
  int          err_count = 0;
  int          check_count = 0;
  kmwi_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .main_power_ok, .kbd_clock_line, .kbd_data_line, .mouse_clock_line,
    .mouse_data_line, .core_kbd_clock, .core_kbd_data, .core_mouse_clock, .core_mouse_data,
    .core_kbd_irq, .core_mouse_irq, .core_kbd_irq_ack, .core_mouse_irq_ack, .kbd_irq_line,
    .mouse_irq_line, .core_reset, .pme_out, .irq);
  kmwi_far_model far (.aclk, .kbd_clock_line, .kbd_data_line, .mouse_clock_line,
    .mouse_data_line, .core_kbd_irq, .core_mouse_irq, .core_kbd_irq_ack, .core_mouse_irq_ack);
  // 40 MHz clock
  always #12.5 aclk = ~aclk;
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    bsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic axi_rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    axi_rd(a);
    chk(rd, exp);
  endtask
  // Events 0,1: core irq rise then rearm; 2,3: data line fall
  task automatic ev(input int e);
    if (e < 2) begin
      far.drive(8'h0F | (8'h10 << e));
      far.drive(8'h0F);
      far.drive(8'h0F | (8'h40 << e));
    end else begin
      far.drive(8'h0F & ~(8'h02 << (2 * (e - 2))));
    end
    far.drive(8'h0F);
    wt(2);
  endtask
  task automatic t_reset_vals();
    logic [11:0] regs [5] = '{12'h02C, 12'h0F0, kmwi_pkg::ADDR_WAKE_STS,
      kmwi_pkg::ADDR_WAKE_EN, kmwi_pkg::ADDR_IRQ_MASK};
    foreach (regs[i]) rchk(regs[i], 32'h0);
    chk(core_reset, 1'h0);
  endtask
  // Core reset bit must stay until software writes zero
  task automatic t_core_reset();
    axi_wr(12'h02C, 32'h40);
    chk(bsp, kmwi_pkg::RESP_OKAY);
    wt(10);
    chk(core_reset, 1'h1);
    rchk(12'h02C, 32'h40);
    axi_wr(12'h02C, 32'h00);
    wt(2);
    chk(core_reset, 1'h0);
    // A write with byte lane 0 off is answered but changes nothing
    s_axi_wstrb <= 4'h0;
    axi_wr(kmwi_pkg::ADDR_CORE_RST, 32'h40);
    s_axi_wstrb <= 4'hF;
    chk(bsp, kmwi_pkg::RESP_OKAY);
    chk(core_reset, 1'h0);
  endtask
  // Isolated lines stay high at the core but still raise wake status
  task automatic t_isolation();
    for (int i = 0; i < 2; i++) begin
      axi_wr(12'h0F0, 32'h20 << i);
      far.drive(i ? 8'h03 : 8'h0C);
      wt(2);
      chk(i ? {core_mouse_clock, core_mouse_data} : {core_kbd_clock, core_kbd_data}, 2'h3);
      far.drive(8'h0F);
      rchk(kmwi_pkg::ADDR_WAKE_STS, 32'h4 << i);
      axi_wr(12'h0F0, 32'h0);
      far.drive(i ? 8'h03 : 8'h0C);
      wt(2);
      chk(i ? {core_mouse_clock, core_mouse_data} : {core_kbd_clock, core_kbd_data}, 2'h0);
      far.drive(8'h0F);
      rchk(kmwi_pkg::ADDR_WAKE_STS, 32'h4 << i);
    end
    chk(core_reset, 1'h0);
  endtask
  // Both latch selects on both channels, with drop and rearm
  task automatic t_latch();
    for (int i = 0; i < 2; i++) begin
      for (int s = 0; s < 2; s++) begin
        axi_wr(12'h0F0, s ? (32'h08 << i) : 32'h0);
        far.drive(8'h0F | (8'h10 << i));
        wt(2);
        chk(i ? mouse_irq_line : kbd_irq_line, 1'h1);
        far.drive(8'h0F);
        wt(2);
        chk(i ? mouse_irq_line : kbd_irq_line, s[0]);
        far.drive(8'h0F | (8'h40 << i));
        far.drive(8'h0F);
        wt(2);
        chk(i ? mouse_irq_line : kbd_irq_line, 1'h0);
      end
    end
    rchk(kmwi_pkg::ADDR_WAKE_STS, 32'h3);
  endtask
  // Distinct status bits; wake needs the global enable; status is sticky
  task automatic t_wake();
    axi_wr(kmwi_pkg::ADDR_WAKE_EN, 32'h0F);
    for (int e = 0; e < 4; e++) begin
      ev(e);
      chk({pme_out, irq}, 2'h0);
      rchk(kmwi_pkg::ADDR_WAKE_STS, 32'h1 << e);
    end
    axi_wr(kmwi_pkg::ADDR_WAKE_EN, 32'h1F);
    axi_wr(kmwi_pkg::ADDR_IRQ_MASK, 32'h0F);
    ev(2);
    wt(5);
    chk({pme_out, irq}, 2'h3);
    rchk(kmwi_pkg::ADDR_WAKE_STS, 32'h4);
    wt(3);
    chk({pme_out, irq}, 2'h0);
  endtask
  // Standby only, lines isolated: irq events ignored, data falls still count;
  // the core is reset once main power returns
  task automatic t_power();
    axi_wr(kmwi_pkg::ADDR_ISO_CTRL, 32'h60);
    @(posedge aclk);
    main_power_ok <= 1'h0;
    for (int e = 0; e < 2; e++) begin
      ev(e);
      ev(e + 2);
      rchk(kmwi_pkg::ADDR_WAKE_STS, 32'h4 << e);
    end
    main_power_ok <= 1'h1;
    axi_wr(kmwi_pkg::ADDR_CORE_RST, 32'h40);
    chk(core_reset, 1'h1);
    axi_wr(kmwi_pkg::ADDR_CORE_RST, 32'h00);
    axi_wr(kmwi_pkg::ADDR_ISO_CTRL, 32'h00);
    chk(core_reset, 1'h0);
  endtask
  task automatic t_unmapped();
    axi_wr(12'h200, 32'hFF);
    chk(bsp, kmwi_pkg::RESP_SLVERR);
    axi_rd(12'h200);
    chk(rsp, kmwi_pkg::RESP_SLVERR);
    chk(rd, 32'h0);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Main sequence after 20 cycles of reset
  initial begin
    wt(20);
    aresetn <= 1'h1;
    t_reset_vals();
    t_core_reset();
    t_isolation();
    t_latch();
    t_wake();
    t_power();
    t_unmapped();
    complete_run();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    wt(20000);
    err_count++;
    complete_run();
  end
endmodule
